// file: pkg/prt_pkg.sv
// Purpose : Shared constants for the periodic down-counting timer.
// Assumes : APB slave with 32-bit data, 12-bit byte address window.
// Notes   : All offsets are byte addresses of aligned 32-bit words.

package prt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and datapath widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int SEL_W  = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [11:0] CSR_OFFS = 12'h000;
   localparam logic [11:0] MOD_OFFS = 12'h004;
   localparam logic [11:0] CNT_OFFS = 12'h008;

   ////////////////////////////////////////////////////////////////////////////
   // Control and status field positions
   localparam int CSR_EN_BIT    = 0;
   localparam int CSR_RLD_BIT   = 1;
   localparam int CSR_FLAG_BIT  = 2;
   localparam int CSR_GATE_BIT  = 3;
   localparam int CSR_WTL_BIT   = 4;
   localparam int CSR_DBG_BIT   = 5;
   localparam int CSR_DOZE_BIT  = 6;
   localparam int CSR_SEL_LSB   = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset, the zero compare value and the wrap value
   localparam logic [15:0] MOD_RST   = 16'hFFFF;
   localparam logic [15:0] CNT_RST   = 16'hFFFF;
   localparam logic [15:0] PSC_RST   = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;
   localparam logic [15:0] CNT_WRAP  = 16'hFFFF;
   localparam logic [3:0]  SEL_RST   = 4'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// file: core/prt_prescaler.sv
// Purpose : Power-of-two clock prescaler producing the decrement enable.
// Assumes : One clock; run and restart come from logic on the same clock.
// Notes   : Tick is a one-cycle enable every 2**sel cycles while running.

`timescale 1ns/100ps

module prt_prescaler
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        run,
   input  wire logic        restart,
   input  wire logic [3:0]  sel,
   // Decrement enable
   output logic             tick
);

   logic [15:0] psc_q;
   logic [15:0] mask;

   // Low sel bits that must all be zero for a tick
   assign mask = ~(16'hFFFF << sel);

   // Prescaler counter, all ones at reset and on each counter load
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         psc_q <= prt_pkg::PSC_RST;
      else if (restart)
         psc_q <= prt_pkg::PSC_RST;
      else if (run)
         psc_q <= psc_q - 16'h0001;
   end

   // One tick per full division period, never while stopped; restart is
   // left out here, so a tick can still fire in the cycle of a write-through load
   assign tick = run && ((psc_q & mask) == 16'h0000);

endmodule

// file: core/prt_apb_decode.sv
// Purpose : APB address decode and access strobes for the timer.
// Assumes : Zero wait states; master follows APB setup/access phases.
// Notes   : Unmapped or misaligned addresses raise the error flag.

`timescale 1ns/100ps

module prt_apb_decode
(
   // APB request
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   // Decoded strobes
   output logic             setup,
   output logic             wr_acc,
   output logic             hit_csr,
   output logic             hit_mod,
   output logic             hit_cnt,
   output logic             miss
);

   // Phase strobes
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite;

   // Register selects
   assign hit_csr = (paddr == prt_pkg::CSR_OFFS);
   assign hit_mod = (paddr == prt_pkg::MOD_OFFS);
   assign hit_cnt = (paddr == prt_pkg::CNT_OFFS);
   assign miss    = !(hit_csr || hit_mod || hit_cnt);

endmodule

// file: core/prt_timer.sv
// Purpose : Periodic down-counting timer with prescaler and APB registers.
// Assumes : Bus clock clk at 20 MHz; doze and debug levels on this clock.
// Notes   : Zero-wait APB slave; read data captured in the setup cycle.
//
// Summary of operation
// - At zero with auto reload set, counter takes the modulus value.
// - With write-through load set, a modulus write loads the counter at once.
// - Prescaler goes to all ones on every counter load and during reset.
// - Reading the modulus register returns the last value written.
// - Reset sets the modulus register to all ones.
// - Count register shows the live sixteen-bit counter; read it whole.
// - Writes to the count register change nothing but complete normally.
// - Reload mode at zero: set flag, load modulus, keep counting down.
// - Without auto reload, counter wraps from zero to all ones.
// - Timeout flag sets on each tick taken while the counter is at zero.
// - Interrupt request whenever timeout flag and its gate are both set.
// - Flag clears by writing one to it or by any modulus write.
// - Prescaler divides the bus clock by two to the select field.
// - With auto reload, timeout period is two to the select times modulus plus one.
// - With enable clear, counter and prescaler stay stopped.
// - Writing zero to the flag does nothing; reset clears it.
// - With doze stop set, timer halts in doze and resumes after.
// - With debug stop set, timer halts in debug; registers stay usable.

`timescale 1ns/100ps

module prt_timer
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // System modes
   input  wire logic        doze_mode,
   input  wire logic        debug_halt,
   // Interrupt request to the CPU
   output logic             timeout_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Decode results
   logic        setup;
   logic        wr_acc;
   logic        hit_csr;
   logic        hit_mod;
   logic        hit_cnt;
   logic        miss;

   // Write strobes per register
   logic        csr_wr_lo;
   logic        csr_wr_hi;
   logic        mod_wr;
   logic [15:0] mod_wr_val;

   // Control bits
   logic        enable_q;
   logic        auto_reload_q;
   logic        flag_request_gate_q;
   logic        write_through_load_q;
   logic        halted_debug_stop_q;
   logic        doze_stop_q;
   logic [3:0]  prescale_sel_q;

   // Status and datapath
   logic        timeout_flag_q;
   logic        timeout_flag_d;
   logic [15:0] modulus_q;
   logic [15:0] counter_value_q;
   logic [15:0] counter_value_d;

   // Timing control
   logic        run;
   logic        tick;
   logic        at_zero;
   logic        zero_evt;
   logic        load_now;
   logic        psc_restart;

   // Read path
   logic [31:0] csr_view;
   logic [31:0] rdata_d;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Address decode and phase strobes
   prt_apb_decode u_decode
   (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .setup   (setup),
      .wr_acc  (wr_acc),
      .hit_csr (hit_csr),
      .hit_mod (hit_mod),
      .hit_cnt (hit_cnt),
      .miss    (miss)
   );

   // Write strobes honour the byte lanes
   assign csr_wr_lo = wr_acc && hit_csr && pstrb[0];
   assign csr_wr_hi = wr_acc && hit_csr && pstrb[1];
   assign mod_wr    = wr_acc && hit_mod && (pstrb[1:0] != 2'b00);

   // Modulus value after a write, merged per byte lane
   assign mod_wr_val = {pstrb[1] ? pwdata[15:8] : modulus_q[15:8],
                        pstrb[0] ? pwdata[7:0]  : modulus_q[7:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   // Enable bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         enable_q <= 1'b0;
      else if (csr_wr_lo)
         enable_q <= pwdata[prt_pkg::CSR_EN_BIT];
   end

   // Auto reload bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         auto_reload_q <= 1'b0;
      else if (csr_wr_lo)
         auto_reload_q <= pwdata[prt_pkg::CSR_RLD_BIT];
   end

   // Request gate for the timeout flag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag_request_gate_q <= 1'b0;
      else if (csr_wr_lo)
         flag_request_gate_q <= pwdata[prt_pkg::CSR_GATE_BIT];
   end

   // Write-through load bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         write_through_load_q <= 1'b0;
      else if (csr_wr_lo)
         write_through_load_q <= pwdata[prt_pkg::CSR_WTL_BIT];
   end

   // Stop-in-debug bit, writable while halted
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         halted_debug_stop_q <= 1'b0;
      else if (csr_wr_lo)
         halted_debug_stop_q <= pwdata[prt_pkg::CSR_DBG_BIT];
   end

   // Stop-in-doze bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         doze_stop_q <= 1'b0;
      else if (csr_wr_lo)
         doze_stop_q <= pwdata[prt_pkg::CSR_DOZE_BIT];
   end

   // Prescale select field in the second byte lane
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prescale_sel_q <= prt_pkg::SEL_RST;
      else if (csr_wr_hi)
         prescale_sel_q <= pwdata[prt_pkg::CSR_SEL_LSB +: prt_pkg::SEL_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout flag

   // Set wins over a clear in the same cycle
   always_comb
   begin
      timeout_flag_d = timeout_flag_q;
      if (mod_wr)
         timeout_flag_d = 1'b0;
      else if (csr_wr_lo && pwdata[prt_pkg::CSR_FLAG_BIT])
         timeout_flag_d = 1'b0;
      if (zero_evt)
         timeout_flag_d = 1'b1;
   end

   // Flag register; writing zero leaves it alone
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timeout_flag_q <= 1'b0;
      else
         timeout_flag_q <= timeout_flag_d;
   end

   // Interrupt request, level while flag and gate are set
   assign timeout_irq = timeout_flag_q && flag_request_gate_q;

   ////////////////////////////////////////////////////////////////////////////
   // Modulus latch

   // Holds the last written value, independent of the count
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         modulus_q <= prt_pkg::MOD_RST;
      else if (mod_wr)
         modulus_q <= mod_wr_val;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run control and prescaler

   // Stopped when disabled, or in doze or debug with the stop bit set
   assign run = enable_q
              && !(doze_stop_q && doze_mode)
              && !(halted_debug_stop_q && debug_halt);

   // Counter state at a decrement step
   assign at_zero  = (counter_value_q == prt_pkg::CNT_ZERO);
   assign zero_evt = tick && at_zero;
   assign load_now = mod_wr && write_through_load_q;

   // A write-through load or a reload at zero restarts the prescaler; a wrap does not
   assign psc_restart = load_now || (zero_evt && auto_reload_q);

   // Power-of-two divider giving the decrement enable
   prt_prescaler u_prescaler
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (run),
      .restart (psc_restart),
      .sel     (prescale_sel_q),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Down-counter

   // Next count: overwrite first, then reload or wrap at zero, else step
   always_comb
   begin
      counter_value_d = counter_value_q;
      if (load_now)
         counter_value_d = mod_wr_val;
      else if (zero_evt && auto_reload_q)
         counter_value_d = modulus_q;
      else if (zero_evt)
         counter_value_d = prt_pkg::CNT_WRAP;
      else if (tick)
         counter_value_d = counter_value_q - 16'h0001;
   end

   // Count register; writes to its address never reach it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         counter_value_q <= prt_pkg::CNT_RST;
      else
         counter_value_q <= counter_value_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Control and status view, reserved bits read zero
   always_comb
   begin
      csr_view = prt_pkg::RDATA_RST;
      csr_view[prt_pkg::CSR_EN_BIT]   = enable_q;
      csr_view[prt_pkg::CSR_RLD_BIT]  = auto_reload_q;
      csr_view[prt_pkg::CSR_FLAG_BIT] = timeout_flag_q;
      csr_view[prt_pkg::CSR_GATE_BIT] = flag_request_gate_q;
      csr_view[prt_pkg::CSR_WTL_BIT]  = write_through_load_q;
      csr_view[prt_pkg::CSR_DBG_BIT]  = halted_debug_stop_q;
      csr_view[prt_pkg::CSR_DOZE_BIT] = doze_stop_q;
      csr_view[prt_pkg::CSR_SEL_LSB +: prt_pkg::SEL_W] = prescale_sel_q;
   end

   // Read mux, zero for unmapped addresses
   always_comb
   begin
      rdata_d = prt_pkg::RDATA_RST;
      if (hit_csr)
         rdata_d = csr_view;
      else if (hit_mod)
         rdata_d = {16'h0000, modulus_q};
      else if (hit_cnt)
         rdata_d = {16'h0000, counter_value_q};
   end

   // Read data captured once per transfer in the setup cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata_q <= prt_pkg::RDATA_RST;
      else if (setup && !pwrite)
         prdata_q <= rdata_d;
   end

   // Error answer for unmapped addresses only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pslverr_q <= 1'b0;
      else if (setup)
         pslverr_q <= miss;
   end

   // Zero wait states: every access phase completes at once
   assign pready  = 1'b1;
   assign pslverr = pslverr_q && psel && penable;
   assign prdata  = prdata_q;

endmodule

// file: sim/prt_timer_properties.sv
// Purpose: Port-level properties of the periodic timer.
// Assumes: Shadows follow completed bus writes; all byte lanes set.
// Notes  : Bound onto prt_timer at the foot of this file.
`timescale 1ns/100ps
module prt_timer_properties
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Modes and request
   input wire logic        doze_mode,
   input wire logic        debug_halt,
   input wire logic        timeout_irq
);
   logic [15:0] mod_q;
   logic [6:0]  csr_q;
   logic        acc;
   logic        wr_csr;
   logic        wr_mod;
   logic        rd_mod;
   logic        quiet;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Decoded accesses
   assign acc    = psel && penable;
   assign wr_csr = acc && pwrite && pstrb[0] && paddr == prt_pkg::CSR_OFFS;
   assign wr_mod = acc && pwrite && paddr == prt_pkg::MOD_OFFS;
   assign rd_mod = acc && !pwrite && paddr == prt_pkg::MOD_OFFS;
   assign quiet  = !timeout_irq && !wr_csr;
   // Shadow of the modulus latch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mod_q <= prt_pkg::MOD_RST;
      else if (wr_mod)
         mod_q <= pwdata[15:0];
   end
   // Shadow of the low control bits
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         csr_q <= 7'h00;
      else if (wr_csr)
         csr_q <= pwdata[6:0];
   end
   ////////////////////////////////////////
   property p_mod_rd; rd_mod |-> prdata[15:0] == mod_q; endproperty
   a_mod_rd: assert property (p_mod_rd)
      else $error("modulus read differs from last write");
   property p_cnt_wr; acc && paddr == prt_pkg::CNT_OFFS |-> pready && !pslverr; endproperty
   a_cnt_wr: assert property (p_cnt_wr)
      else $error("count access not ended normally");
   property p_gate; timeout_irq |-> csr_q[3]; endproperty
   a_gate: assert property (p_gate)
      else $error("request raised with gate clear");
   property p_w0; wr_csr && !pwdata[2] && pwdata[3] && timeout_irq |=> timeout_irq; endproperty
   a_w0: assert property (p_w0)
      else $error("writing zero cleared the flag");
   property p_w1c; wr_csr && pwdata[2] && !csr_q[0] |=> !timeout_irq; endproperty
   a_w1c: assert property (p_w1c)
      else $error("flag not cleared by writing one");
   property p_modclr; wr_mod && !csr_q[0] |=> !timeout_irq; endproperty
   a_modclr: assert property (p_modclr)
      else $error("flag not cleared by modulus write");
   property p_off; !csr_q[0] && quiet |=> !timeout_irq; endproperty
   a_off: assert property (p_off)
      else $error("timeout while disabled");
   property p_doze; csr_q[6] && doze_mode && $past(doze_mode) && quiet |=> !timeout_irq;
   endproperty
   a_doze: assert property (p_doze)
      else $error("timeout while doze stopped");
   property p_dbg; csr_q[5] && debug_halt && $past(debug_halt) && quiet |=> !timeout_irq;
   endproperty
   a_dbg: assert property (p_dbg)
      else $error("timeout while debug stopped");
endmodule
bind prt_timer prt_timer_properties u_props
(
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .doze_mode(doze_mode), .debug_halt(debug_halt),
   .timeout_irq(timeout_irq)
);

// file: sim/prt_apb_host.sv
// Purpose: Bus host model standing in for the CPU.
// Assumes: Requests launch right after a rising edge.
// Notes  : Write data is inverted once the bus is released.
`timescale 1ns/100ps
module prt_apb_host
(
   // Clock
   input wire logic        clk,
   // Bus request
   output logic            psel,
   output logic            penable,
   output logic            pwrite,
   output logic [11:0]     paddr,
   output logic [31:0]     pwdata,
   output logic [3:0]      pstrb,
   // Bus answer
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic [31:0] rd_q;
   logic        err_q;
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
   end
   ////////////////////////////////////////
   // Setup, access until ready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

// file: sim/test_periodic_interrupt_timer.sv
// Purpose: Self-checking bench for the periodic timer.
// Assumes: Host model issues every bus transfer.
// Notes  : Periods are counted in clocks from the enabling write.
`timescale 1ns/100ps
module test_periodic_interrupt_timer;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        doze_mode;
   logic        debug_halt;
   logic        timeout_irq;
   logic [15:0] m;
   logic [3:0]  s;
   int          err_total;
   int          checks;
   int          cyc;
   int          lcyc;
   int          t;
   prt_timer dut
   (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .doze_mode(doze_mode), .debug_halt(debug_halt),
      .timeout_irq(timeout_irq)
   );
   prt_apb_host host
   (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );
   // Clock and cycle count
   always #25 clk = ~clk;
   always @(posedge clk)
      cyc <= cyc + 1;
   ////////////////////////////////////////
   function automatic logic [31:0] csr(input logic [3:0] sv, input logic [6:0] b);
      return {20'h0_0000, sv, 1'b0, b};
   endfunction
   function automatic int period(input logic [15:0] mv, input logic [3:0] sv);
      return (int'(mv) + 1) << sv;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0000_0000);
      check(host.rd_q, e);
   endtask
   // Wait for the request; stamp the cycle of its edge
   task automatic wait_irq();
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (timeout_irq !== 1'b1 && n < 70000)
      begin
         n++;
         @(posedge clk);
         #1;
      end
      t = cyc;
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////
   // Reset, register map, stopped loads, periods
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      doze_mode = 1'b0;
      debug_halt = 1'b0;
      err_total = 0;
      checks = 0;
      cyc = 0;
      void'($urandom(32'h0000_625a));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(prt_pkg::MOD_OFFS, 32'h0000_FFFF);
      rd(prt_pkg::CSR_OFFS, 32'h0000_0000);
      host.xfer(1'b1, prt_pkg::CNT_OFFS, 32'h0000_1234);
      check(32'(host.err_q), 32'h0000_0000);
      rd(prt_pkg::CNT_OFFS, 32'h0000_FFFF);
      m = 16'($urandom);
      host.xfer(1'b1, prt_pkg::MOD_OFFS, {16'h0000, m});
      rd(prt_pkg::MOD_OFFS, {16'h0000, m});
      rd(prt_pkg::CNT_OFFS, 32'h0000_FFFF);
      rd(12'h00C, 32'h0000_0000);
      check(32'(host.err_q), 32'h0000_0001);
      for (int k = 0; k < 3; k++)
      begin
         m = 16'($urandom);
         doze_mode <= (k == 1);
         debug_halt <= (k == 2);
         host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(4'h0, k == 0 ? 7'h14 : k == 1 ? 7'h51 : 7'h31));
         host.xfer(1'b1, prt_pkg::MOD_OFFS, {16'h0000, m});
         repeat (5) @(posedge clk);
         rd(prt_pkg::CNT_OFFS, {16'h0000, m});
         rd(prt_pkg::MOD_OFFS, {16'h0000, m});
      end
      doze_mode <= 1'b0;
      debug_halt <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         // Periods of at least 8 keep the next zero off the flag-clear edge
         m = (i == 0) ? 16'h0000 : 16'($urandom_range(40, 7));
         s = (i == 0) ? 4'h0 : 4'($urandom_range(3, 0));
         host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(s, i == 6 ? 7'h18 : 7'h1C));
         host.xfer(1'b1, prt_pkg::MOD_OFFS, {16'h0000, m});
         host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(s, i == 6 ? 7'h19 : 7'h1B));
         #1 lcyc = cyc;
         wait_irq();
         check(t - lcyc, period(m, s));
         host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(s, i == 6 ? 7'h19 : 7'h1B));
         #1 check(32'(timeout_irq), 32'h0000_0001);
         host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(s, i == 6 ? 7'h1D : 7'h1F));
         if (i < 6)
         begin
            wait_irq();
            check((t - lcyc) % period(m, s), 32'h0000_0000);
            host.xfer(1'b1, prt_pkg::CSR_OFFS, csr(s, 7'h13));
            #1 check(32'(timeout_irq), 32'h0000_0000);
         end
      end
      repeat (40) @(posedge clk);
      #1 check(32'(timeout_irq), 32'h0000_0000);
      host.xfer(1'b0, prt_pkg::CNT_OFFS, 32'h0000_0000);
      check(32'(host.rd_q[15:8]), 32'h0000_00FF);
      end_of_test();
   end
   // Watchdog against a hung wait
   initial
   begin
      #(50 * 30000);
      err_total++;
      end_of_test();
   end
endmodule
